// file: scm_top.sv
// What this block does
// - select code picks fast/1..64 or slow
// - fast source bit picks rc or crystal
// - slow source bit picks rc or crystal
// - halt with no idle bits: sleep
// - sleep keeps slow rc only for watchdog
// - idle_slow_only_mode: slow clock on, sys on if 111
// - idle_both_on_mode: all clocks stay running
// - idle_fast_only_mode: fast on, sys stops for 111
// - watchdog keeps slow rc oscillator enabled
// - slow mode: fast oscillator follows own enable
// - rc freq codes give 8/12/16/8 MHz
// - rc flag clears, sets when stable
// - new rc frequency applied after flag
// - rc enable bit, reset to one
// - unimplemented bits read as zero
// - fast crystal flag clears then sets
// - slow crystal flag clears then sets
module scm_top #(
	parameter int STAB_FRC = scm_pkg::STAB_FRC_DEF,
	parameter int STAB_FXT = scm_pkg::STAB_FXT_DEF,
	parameter int STAB_SXT = scm_pkg::STAB_SXT_DEF
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// cpu side
	input  wire logic        halt_req,
	input  wire logic        wake_req,
	input  wire logic        wdt_enable,
	output logic             cpu_run,
	// oscillator clock ticks
	input  wire logic        fast_rc_tick,
	input  wire logic        fast_xtal_tick,
	input  wire logic        slow_rc_tick,
	input  wire logic        slow_xtal_tick,
	// oscillator enables
	output logic             fast_rc_osc_en,
	output logic             fast_xtal_osc_en,
	output logic             slow_rc_osc_en,
	output logic             slow_xtal_osc_en,
	output logic [4:0]       fast_rc_mhz,
	output logic             fast_xtal_range,
	// derived clocks as enable pulses
	output logic             system_clock,
	output logic             high_speed_clock,
	output logic             low_speed_clock,
	output logic [5:0]       high_speed_div,
	// interrupt
	output logic             irq
);
	// software registers
	logic [7:0]               clk_mode_ff;    // clock mode control
	logic [1:0]               frc_freq_ff;    // requested rc frequency
	logic                     frc_en_ff;      // rc enable
	logic                     fxt_mode_ff;    // crystal range
	logic                     fxt_en_ff;      // fast crystal enable
	logic                     sxt_en_ff;      // slow crystal enable
	logic [1:0]               frc_applied_ff; // frequency in use
	logic [scm_pkg::IRQ_W-1:0] irq_stat_ff;   // sticky events
	logic [scm_pkg::IRQ_W-1:0] irq_mask_ff;   // enables
	scm_pkg::scm_mode_t       mode_ff;        // operating mode
	scm_pkg::scm_mode_t       nxt_mode;

	// registered outputs
	logic [31:0] prdata_ff;   // read data, caught in setup
	logic        ready_ff;    // bus ready, high once out of reset
	logic        slverr_ff;   // error for the access cycle
	logic        sys_ff;      // system clock pulse
	logic        hs_ff;       // high-speed clock pulse
	logic        ls_ff;       // low-speed clock pulse
	logic        irq_ff;      // interrupt level
	logic        cpu_ff;      // cpu running
	logic [5:0]  hdiv_ff;     // divided high-speed pulses
	logic        frc_osc_ff;  // fast rc enable
	logic        fxt_osc_ff;  // fast crystal enable
	logic        src_osc_ff;  // slow rc enable
	logic        sxt_osc_ff;  // slow crystal enable
	logic [4:0]  mhz_ff;      // applied rc frequency

	// field views
	wire [2:0] sel     = clk_mode_ff[scm_pkg::CMC_SEL_LSB +: 3];
	wire       fast_source_select     = clk_mode_ff[scm_pkg::CMC_FHS_BIT];
	wire       slow_source_select     = clk_mode_ff[scm_pkg::CMC_FSS_BIT];
	wire       fh_idle = clk_mode_ff[scm_pkg::CMC_FHI_BIT];
	wire       fs_idle = clk_mode_ff[scm_pkg::CMC_FSI_BIT];
	wire       sel_slow = (sel == scm_pkg::SEL_SLOW);

	// apb decode
	wire acc     = psel & penable;
	wire setup   = psel & ~penable;                  // setup cycle
	wire wr      = acc & pwrite;
	wire a_cmc   = (paddr == scm_pkg::OFS_CLK_MODE);
	wire a_frc   = (paddr == scm_pkg::OFS_FAST_RC);
	wire a_fxt   = (paddr == scm_pkg::OFS_FAST_XTAL);
	wire a_sxt   = (paddr == scm_pkg::OFS_SLOW_XTAL);
	wire a_ist   = (paddr == scm_pkg::OFS_IRQ_STAT);
	wire a_imk   = (paddr == scm_pkg::OFS_IRQ_MASK);
	wire a_sts   = (paddr == scm_pkg::OFS_STATUS);
	wire mapped  = a_cmc | a_frc | a_fxt | a_sxt | a_ist | a_imk | a_sts
		| (paddr == scm_pkg::OFS_CTRL);
	// unmapped words answer with an error and read as zero
	wire unmapped = ~mapped;

	// mode decode
	// wake counts as run so the cpu restarts at once
	wire in_run   = (mode_ff == scm_pkg::MODE_RUN) | (mode_ff == scm_pkg::MODE_WAKE);
	wire in_sleep = (mode_ff == scm_pkg::MODE_SLEEP);
	wire in_idl0  = (mode_ff == scm_pkg::MODE_IDL0);
	wire in_idl1  = (mode_ff == scm_pkg::MODE_IDL1);
	wire in_idl2  = (mode_ff == scm_pkg::MODE_IDL2);

	// oscillator gating by mode
	wire hs_allowed = in_run | in_idl1 | in_idl2;
	wire ls_allowed = in_run | in_idl0 | in_idl1;
	wire frc_on  = frc_en_ff & (in_run ? 1'b1 : (hs_allowed & ~fast_source_select));
	wire fxt_on  = fxt_en_ff & (in_run ? 1'b1 : (hs_allowed & fast_source_select));
	wire src_on  = (ls_allowed & ~slow_source_select) | wdt_enable;
	wire sxt_on  = sxt_en_ff & ls_allowed;
	wire sxt_run = sxt_on | (ls_allowed & slow_source_select);

	// stability counters
	logic frc_stable;                              // rc settled
	logic fxt_stable;                              // fast crystal settled
	logic sxt_stable;                              // slow crystal settled
	// rewriting the same code must not restart the count
	wire  frc_freq_chg = wr & a_frc
		& (pwdata[scm_pkg::FRC_FREQ_LSB +: 2] != frc_freq_ff);
	scm_stab #(.CYCLES(STAB_FRC)) u_frc_stab (
		.pclk    (pclk),
		.presetn (presetn),
		.enable  (frc_on),
		.restart (frc_freq_chg),
		.stable  (frc_stable)
	);
	scm_stab #(.CYCLES(STAB_FXT)) u_fxt_stab (
		.pclk    (pclk),
		.presetn (presetn),
		.enable  (fxt_on),
		.restart (1'b0),
		.stable  (fxt_stable)
	);
	scm_stab #(.CYCLES(STAB_SXT)) u_sxt_stab (
		.pclk    (pclk),
		.presetn (presetn),
		.enable  (sxt_run),
		.restart (1'b0),
		.stable  (sxt_stable)
	);

	// clock source muxing
	// the crystals and the fast rc pass ticks only once settled, the slow rc whenever enabled
	wire fxt_tick_g = fast_xtal_tick & fxt_on & fxt_stable;
	wire frc_tick_g = fast_rc_tick & frc_on & frc_stable;
	wire fh_tick    = fast_source_select ? fxt_tick_g : frc_tick_g;
	wire low_speed_clock_tick = slow_source_select ? (slow_xtal_tick & sxt_run & sxt_stable)
		: (slow_rc_tick & src_on);
	wire [5:0] fh_div;
	scm_div #(.STAGES(6)) u_div (
		.pclk     (pclk),
		.presetn  (presetn),
		.src_tick (fh_tick),
		.div_tick (fh_div)
	);
	// select code to system clock source, code 111 is the slow tick
	wire [7:0] clk_pick = {low_speed_clock_tick, fh_div, fh_tick};
	wire sys_src = clk_pick[sel];
	wire sys_gate = in_run | in_idl1 | (in_idl0 & sel_slow)
		| (in_idl2 & ~sel_slow);

	// rc frequency code to MHz
	wire [4:0] mhz = (frc_applied_ff == 2'h1) ? scm_pkg::FRC_MHZ_12
		: (frc_applied_ff == 2'h2) ? scm_pkg::FRC_MHZ_16 : scm_pkg::FRC_MHZ_8;

	// register readback, unimplemented bits zero
	wire [7:0] rd_cmc = clk_mode_ff & scm_pkg::CMC_WMASK;
	wire [7:0] rd_frc = {4'h0, frc_freq_ff, frc_stable, frc_en_ff};
	wire [7:0] rd_fxt = {5'h00, fxt_mode_ff, fxt_stable, fxt_en_ff};
	wire [7:0] rd_sxt = {6'h00, sxt_stable, sxt_en_ff};
	wire [7:0] rd_sts = {2'h0, mode_ff};
	wire [7:0] rd_mux = a_cmc ? rd_cmc : a_frc ? rd_frc : a_fxt ? rd_fxt
		: a_sxt ? rd_sxt : a_ist ? {4'h0, irq_stat_ff}
		: a_imk ? {4'h0, irq_mask_ff} : a_sts ? rd_sts : 8'h00;

	// events: rising stable flags, halt entry
	logic frc_st_d_ff;                             // rc flag one cycle ago
	logic fxt_st_d_ff;                             // fast crystal flag one cycle ago
	logic sxt_st_d_ff;                             // slow crystal flag one cycle ago
	wire halt_take = in_run & halt_req;
	wire [scm_pkg::IRQ_W-1:0] ev = {halt_take, sxt_stable & ~sxt_st_d_ff,
		fxt_stable & ~fxt_st_d_ff, frc_stable & ~frc_st_d_ff};
	wire [scm_pkg::IRQ_W-1:0] w1c = (wr & a_ist) ? pwdata[scm_pkg::IRQ_W-1:0] : '0;

	// next mode on halt or wake
	always_comb begin
		nxt_mode = mode_ff;
		case (mode_ff)
			scm_pkg::MODE_RUN, scm_pkg::MODE_WAKE: begin
				if (halt_req) begin
					case ({fh_idle, fs_idle})
						2'b00:   nxt_mode = scm_pkg::MODE_SLEEP;
						2'b01:   nxt_mode = scm_pkg::MODE_IDL0;
						2'b11:   nxt_mode = scm_pkg::MODE_IDL1;
						default: nxt_mode = scm_pkg::MODE_IDL2;
					endcase
				end else begin
					nxt_mode = scm_pkg::MODE_RUN;
				end
			end
			scm_pkg::MODE_SLEEP, scm_pkg::MODE_IDL0,
			scm_pkg::MODE_IDL1, scm_pkg::MODE_IDL2: begin
				if (wake_req)
					nxt_mode = scm_pkg::MODE_WAKE;
			end
			default: nxt_mode = scm_pkg::MODE_RUN;
		endcase
	end

	// registers written over apb
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_mode_ff <= scm_pkg::RST_CLK_MODE;
			frc_freq_ff <= scm_pkg::RST_FAST_RC[scm_pkg::FRC_FREQ_LSB +: 2];
			frc_en_ff   <= scm_pkg::RST_FAST_RC[scm_pkg::EN_BIT];
			fxt_mode_ff <= scm_pkg::RST_FAST_XTAL[scm_pkg::FXT_MODE_BIT];
			fxt_en_ff   <= scm_pkg::RST_FAST_XTAL[scm_pkg::EN_BIT];
			sxt_en_ff   <= scm_pkg::RST_SLOW_XTAL[scm_pkg::EN_BIT];
			irq_mask_ff <= '0;
		end else if (wr) begin
			if (a_cmc)
				clk_mode_ff <= pwdata[7:0] & scm_pkg::CMC_WMASK;
			if (a_frc) begin
				frc_freq_ff <= pwdata[scm_pkg::FRC_FREQ_LSB +: 2];
				frc_en_ff   <= pwdata[scm_pkg::EN_BIT];
			end
			if (a_fxt) begin
				// range bit frozen while crystal enabled
				if (!fxt_en_ff)
					fxt_mode_ff <= pwdata[scm_pkg::FXT_MODE_BIT];
				fxt_en_ff <= pwdata[scm_pkg::EN_BIT];
			end
			if (a_sxt)
				sxt_en_ff <= pwdata[scm_pkg::EN_BIT];
			if (a_imk)
				irq_mask_ff <= pwdata[scm_pkg::IRQ_W-1:0];
		end
	end

	// applied rc frequency waits for stable flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			frc_applied_ff <= scm_pkg::RST_FAST_RC[scm_pkg::FRC_FREQ_LSB +: 2];
		else if (frc_stable)
			frc_applied_ff <= frc_freq_ff;
	end

	// mode, sticky status, edge history
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_ff     <= scm_pkg::MODE_RUN;
			irq_stat_ff <= '0;
			frc_st_d_ff <= 1'b0;
			fxt_st_d_ff <= 1'b0;
			sxt_st_d_ff <= 1'b0;
		end else begin
			mode_ff     <= nxt_mode;
			irq_stat_ff <= (irq_stat_ff & ~w1c) | ev;  // set beats clear
			frc_st_d_ff <= frc_stable;
			fxt_st_d_ff <= fxt_stable;
			sxt_st_d_ff <= sxt_stable;
		end
	end

	// registered outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff  <= '0;
			sys_ff     <= 1'b0;
			hs_ff      <= 1'b0;
			ls_ff      <= 1'b0;
			hdiv_ff    <= '0;
			irq_ff     <= 1'b0;
			cpu_ff     <= 1'b1;
			frc_osc_ff <= 1'b0;
			fxt_osc_ff <= 1'b0;
			src_osc_ff <= 1'b0;
			sxt_osc_ff <= 1'b0;
			mhz_ff     <= scm_pkg::FRC_MHZ_8;
		end else begin
			prdata_ff  <= (setup & ~pwrite) ? {24'h000000, rd_mux} : prdata_ff;
			sys_ff     <= sys_src & sys_gate;
			hs_ff      <= fh_tick & hs_allowed;
			ls_ff      <= low_speed_clock_tick & ls_allowed;
			hdiv_ff    <= fh_div & {6{hs_allowed}};
			irq_ff     <= |((irq_stat_ff & ~w1c | ev) & irq_mask_ff);
			cpu_ff     <= (nxt_mode == scm_pkg::MODE_RUN) | (nxt_mode == scm_pkg::MODE_WAKE);
			frc_osc_ff <= frc_on;
			fxt_osc_ff <= fxt_on;
			src_osc_ff <= src_on;
			sxt_osc_ff <= sxt_run;
			mhz_ff     <= mhz;
		end
	end

	// bus response flops, error stands for the access cycle only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ready_ff  <= 1'b0;
			slverr_ff <= 1'b0;
		end else begin
			ready_ff  <= 1'b1;
			slverr_ff <= setup & unmapped;
		end
	end

	// apb answers in the access cycle, no wait states
	assign prdata           = prdata_ff;
	assign pready           = ready_ff;
	assign pslverr          = slverr_ff;
	assign cpu_run          = cpu_ff;
	assign fast_rc_osc_en   = frc_osc_ff;
	assign fast_xtal_osc_en = fxt_osc_ff;
	assign slow_rc_osc_en   = src_osc_ff;
	assign slow_xtal_osc_en = sxt_osc_ff;
	assign fast_rc_mhz      = mhz_ff;
	assign fast_xtal_range  = fxt_mode_ff;
	assign system_clock     = sys_ff;
	assign high_speed_clock = hs_ff;
	assign low_speed_clock  = ls_ff;
	assign high_speed_div   = hdiv_ff;
	assign irq              = irq_ff;
endmodule

// file: scm_pkg.sv
package scm_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CLK_MODE   = 8'h00;
	localparam logic [7:0] OFS_FAST_RC    = 8'h04;
	localparam logic [7:0] OFS_FAST_XTAL  = 8'h08;
	localparam logic [7:0] OFS_SLOW_XTAL  = 8'h0C;
	localparam logic [7:0] OFS_CTRL       = 8'h10;
	localparam logic [7:0] OFS_IRQ_STAT   = 8'h14;
	localparam logic [7:0] OFS_IRQ_MASK   = 8'h18;
	localparam logic [7:0] OFS_STATUS     = 8'h1C;
	// reset values
	localparam logic [7:0] RST_CLK_MODE   = 8'h00;
	localparam logic [7:0] RST_FAST_RC    = 8'h01;
	localparam logic [7:0] RST_FAST_XTAL  = 8'h00;
	localparam logic [7:0] RST_SLOW_XTAL  = 8'h00;
	// clock mode register fields
	localparam int CMC_SEL_LSB  = 5;
	localparam int CMC_FHS_BIT  = 3;
	localparam int CMC_FSS_BIT  = 2;
	localparam int CMC_FHI_BIT  = 1;
	localparam int CMC_FSI_BIT  = 0;
	localparam logic [7:0] CMC_WMASK = 8'hEF;
	// fast rc and crystal fields
	localparam int FRC_FREQ_LSB = 2;
	localparam int STB_BIT      = 1;
	localparam int EN_BIT       = 0;
	localparam logic [7:0] FRC_WMASK = 8'h0D;
	localparam logic [7:0] FXT_WMASK = 8'h05;
	localparam int FXT_MODE_BIT = 2;
	localparam logic [7:0] SXT_WMASK = 8'h01;
	// select code for low-speed clock
	localparam logic [2:0] SEL_SLOW = 3'h7;
	// fast rc frequency codes in MHz
	localparam logic [4:0] FRC_MHZ_8  = 5'h08;
	localparam logic [4:0] FRC_MHZ_12 = 5'h0C;
	localparam logic [4:0] FRC_MHZ_16 = 5'h10;
	// interrupt bits
	localparam int IRQ_W      = 4;
	localparam int IRQ_FRC    = 0;
	localparam int IRQ_FXT    = 1;
	localparam int IRQ_SXT    = 2;
	localparam int IRQ_HALT   = 3;
	// default stabilisation counts in pclk cycles
	localparam int STAB_FRC_DEF = 64;
	localparam int STAB_FXT_DEF = 256;
	localparam int STAB_SXT_DEF = 1024;
	localparam int CNT_W        = 16;
	// operating modes, one-hot
	typedef enum logic [5:0] {
		MODE_RUN   = 6'h01,
		MODE_SLEEP = 6'h02,
		MODE_IDL0  = 6'h04,
		MODE_IDL1  = 6'h08,
		MODE_IDL2  = 6'h10,
		MODE_WAKE  = 6'h20
	} scm_mode_t;
endpackage

// file: scm_stab.sv
// start-up counter: flag clears on start, sets when count runs out
module scm_stab #(
	parameter int CYCLES = 64
) (
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// control
	input  wire logic enable,
	input  wire logic restart,
	// result
	output logic      stable
);
	logic [scm_pkg::CNT_W-1:0] cnt_ff;   // cycles left
	logic                      stable_ff;
	logic                      en_d_ff;  // enable one cycle ago
	wire                       start = (enable & ~en_d_ff) | restart;

	// count down after each start, flag when done
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff    <= '0;
			stable_ff <= 1'b0;
			en_d_ff   <= 1'b0;
		end else begin
			en_d_ff <= enable;
			if (!enable) begin
				stable_ff <= 1'b0;
				cnt_ff    <= '0;
			end else if (start) begin
				stable_ff <= 1'b0;
				cnt_ff    <= scm_pkg::CNT_W'(CYCLES - 1);
			end else if (cnt_ff != '0) begin
				cnt_ff <= cnt_ff - 1'b1;
			end else begin
				stable_ff <= 1'b1;
			end
		end
	end
	assign stable = stable_ff;
endmodule

// file: scm_div.sv
// divider chain: one-cycle enable pulses at source/2..source/64
module scm_div #(
	parameter int STAGES = 6
) (
	// clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// source tick
	input  wire logic              src_tick,
	// divided ticks, bit k is source / 2^(k+1)
	output logic [STAGES-1:0]      div_tick
);
	logic [STAGES-1:0] cnt_ff;  // ripple counter on source ticks

	// advance on each source tick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cnt_ff <= '0;
		else if (src_tick)
			cnt_ff <= cnt_ff + 1'b1;
	end

	// tick when all lower bits are ones
	genvar k;
	generate
		for (k = 0; k < STAGES; k++) begin : g_tick
			assign div_tick[k] = src_tick & (&cnt_ff[k:0]);
		end
	endgenerate
endmodule

// file: scm_properties.sv
module scm_properties (
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// register bus
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	// cpu side
	input wire logic        halt_req,
	input wire logic        wake_req,
	input wire logic        wdt_enable,
	input wire logic        cpu_run,
	// oscillators and derived clocks
	input wire logic        fast_rc_osc_en,
	input wire logic        fast_xtal_osc_en,
	input wire logic        slow_rc_osc_en,
	input wire logic        system_clock,
	input wire logic        high_speed_clock,
	input wire logic        low_speed_clock
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic [7:0] cmc_ff;                                   // shadow of clock mode register
	logic [7:0] nxt_cmc;                                  // shadow next value
	wire        acc_w   = psel && penable;                // access phase
	wire        rd_w    = acc_w && !pwrite;               // read access
	wire [2:0]  sel_w   = cmc_ff[7:5];                    // system clock select
	wire        sleep_w = !cpu_run && cmc_ff[1:0] == 2'h0; // halted, no idle bits
	wire        idle_slow_only_mode_w = !cpu_run && cmc_ff[1:0] == 2'h1; // halted, slow only
	wire        idle_fast_only_mode_w = !cpu_run && cmc_ff[1:0] == 2'h2; // halted, fast only
	wire        cmc_wr  = acc_w && pwrite && paddr == scm_pkg::OFS_CLK_MODE;
	assign nxt_cmc = cmc_wr ? (pwdata[7:0] & scm_pkg::CMC_WMASK) : cmc_ff;
	// shadow follows accepted writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmc_ff <= scm_pkg::RST_CLK_MODE;
		end else begin
			cmc_ff <= nxt_cmc;
		end
	end
	// halt modes given three cycles to settle
	sequence s_sleep;
		sleep_w [*3];
	endsequence
	sequence s_idle_slow_only_mode_fast;
		(idle_slow_only_mode_w && sel_w != scm_pkg::SEL_SLOW) [*3];
	endsequence
	property p_err;
		acc_w && paddr[1:0] == 2'h0 |-> pslverr == (paddr > scm_pkg::OFS_STATUS);
	endproperty
	a_err: assert property (p_err) else $error("slave error does not match map");
	property p_rsv;
		rd_w && (paddr == scm_pkg::OFS_CLK_MODE || paddr == scm_pkg::OFS_FAST_RC)
			|-> prdata[31:8] == 24'h0 && !prdata[4]
			&& (paddr == scm_pkg::OFS_CLK_MODE || prdata[7:5] == 3'h0);
	endproperty
	a_rsv: assert property (p_rsv) else $error("unused bits read nonzero");
	property p_halt;
		halt_req && cpu_run && !wake_req |=> !cpu_run;
	endproperty
	a_halt: assert property (p_halt) else $error("halt not taken");
	property p_wake;
		wake_req && !cpu_run |=> cpu_run;
	endproperty
	a_wake: assert property (p_wake) else $error("wake not taken");
	property p_sleep_off;
		s_sleep |-> !fast_rc_osc_en && !fast_xtal_osc_en && !system_clock
			&& !high_speed_clock && !low_speed_clock;
	endproperty
	a_sleep_off: assert property (p_sleep_off) else $error("clock alive in sleep");
	property p_sleep_wdt;
		(sleep_w && $stable(wdt_enable)) [*3] |-> slow_rc_osc_en == wdt_enable;
	endproperty
	a_sleep_wdt: assert property (p_sleep_wdt) else $error("slow rc wrong in sleep");
	property p_wdt;
		wdt_enable [*3] |-> slow_rc_osc_en;
	endproperty
	a_wdt: assert property (p_wdt) else $error("slow rc off with watchdog");
	property p_idle_slow_only_mode;
		s_idle_slow_only_mode_fast |-> !system_clock && !high_speed_clock;
	endproperty
	a_idle_slow_only_mode: assert property (p_idle_slow_only_mode) else $error("fast clock alive in idle_slow_only_mode");
	property p_idle_fast_only_mode;
		idle_fast_only_mode_w [*3] |-> !low_speed_clock && !(sel_w == scm_pkg::SEL_SLOW && system_clock);
	endproperty
	a_idle_fast_only_mode: assert property (p_idle_fast_only_mode) else $error("slow clock alive in idle_fast_only_mode");
	property p_sel;
		(cpu_run && sel_w == 3'h0) [*2] |-> system_clock == high_speed_clock;
	endproperty
	a_sel: assert property (p_sel) else $error("undivided select wrong");
endmodule

bind scm_top scm_properties scm_properties_i (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pslverr(pslverr), .halt_req(halt_req), .wake_req(wake_req), .wdt_enable(wdt_enable),
	.cpu_run(cpu_run), .fast_rc_osc_en(fast_rc_osc_en), .fast_xtal_osc_en(fast_xtal_osc_en),
	.slow_rc_osc_en(slow_rc_osc_en), .system_clock(system_clock),
	.high_speed_clock(high_speed_clock), .low_speed_clock(low_speed_clock));

// file: scm_osc_model.sv
module scm_osc_model #(
	parameter int P_FRC = 2,  // fast rc tick spacing
	parameter int P_FXT = 3,  // fast crystal tick spacing
	parameter int P_SRC = 16, // slow rc tick spacing
	parameter int P_SXT = 20  // slow crystal tick spacing
) (
	// clock and reset
	input wire logic       pclk,
	input wire logic       presetn,
	// enables: rc, crystal, slow rc, slow crystal
	input wire logic [3:0] osc_en,
	// one-cycle ticks, same order
	output logic     [3:0] osc_tick
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PER [4] = '{P_FRC, P_FXT, P_SRC, P_SXT}; // spacing per oscillator
	logic [4:0] cnt_ff [4];                                   // phase counters
	// a stopped oscillator stands still, no stray ticks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_tick <= 4'h0;
			cnt_ff <= '{default: 5'h00};
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (!osc_en[i] || cnt_ff[i] == 5'(PER[i] - 1)) begin
					cnt_ff[i] <= 5'h00;
				end else begin
					cnt_ff[i] <= cnt_ff[i] + 5'h01;
				end
				osc_tick[i] <= osc_en[i] && cnt_ff[i] == 5'(PER[i] - 1);
			end
		end
	end
endmodule

// file: system_clock_mode_control_tb_top.sv
module system_clock_mode_control_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int STAB = 8;                               // short start-up count
	localparam logic [7:0] MODE_V [4] = '{8'h02, 8'h04, 8'h10, 8'h08}; // mode by idle bits
	logic        pclk, presetn, psel, penable, pwrite;     // bus and reset
	logic [7:0]  paddr, rnd, md;                           // address, scratch
	logic [31:0] pwdata, prdata;                           // bus data
	logic        pready, pslverr, irq, cpu_run, xt_rng;    // block status
	logic        halt_req, wake_req, wdt_enable;           // cpu side
	logic [3:0]  osc_en, osc_tick;                         // oscillator handshake
	logic [4:0]  rc_mhz;                                   // applied rc rate
	logic        sys_clk, hs_clk, ls_clk;                  // derived ticks
	logic [5:0]  hs_div;                                   // divided fast ticks
	logic [31:0] exp_q [$];                                // expected read data
	int          mismatches, checks_done, seed, ns, nh, nl, nd;
	scm_top #(.STAB_FRC(STAB), .STAB_FXT(STAB), .STAB_SXT(STAB)) scm_top_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.halt_req(halt_req), .wake_req(wake_req), .wdt_enable(wdt_enable), .cpu_run(cpu_run),
		.fast_rc_tick(osc_tick[0]), .fast_xtal_tick(osc_tick[1]), .slow_rc_tick(osc_tick[2]),
		.slow_xtal_tick(osc_tick[3]), .fast_rc_osc_en(osc_en[0]), .fast_xtal_osc_en(osc_en[1]),
		.slow_rc_osc_en(osc_en[2]), .slow_xtal_osc_en(osc_en[3]), .fast_rc_mhz(rc_mhz),
		.fast_xtal_range(xt_rng), .system_clock(sys_clk), .high_speed_clock(hs_clk),
		.low_speed_clock(ls_clk), .high_speed_div(hs_div), .irq(irq));
	scm_osc_model scm_osc_model_i (.pclk(pclk), .presetn(presetn), .osc_en(osc_en),
		.osc_tick(osc_tick));
	// 50 MHz clock
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	// cuts a hang short
	initial begin
		repeat (20000) @(posedge pclk);
		mismatches++;
		results();
	end
	task results;
		if (mismatches == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	// pulse counts allow for tick phase
	task near(input string nm, input int e, input int g);
		checks_done++;
		if (g > e + 2 || g < e - 2) begin
			mismatches++;
			$display("[ERR] %s expected %0d seen %0d", nm, e, g);
		end
	endtask
	task idle(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// one transfer: setup, access until ready, then release
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] r;
		r = $random(seed);
		apb(1'b1, a, {r[31:8], d});
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back({24'h0, e});
		apb(1'b0, a, 32'h0);
	endtask
	// one-cycle halt or wake request
	task hw(input logic h);
		halt_req <= h;
		wake_req <= !h;
		@(posedge pclk);
		halt_req <= 1'b0;
		wake_req <= 1'b0;
		@(posedge pclk);
	endtask
	task cnt(input int n);
		ns = 0;
		nh = 0;
		nl = 0;
		nd = 0;
		repeat (n) begin
			@(posedge pclk);
			ns += sys_clk;
			nh += hs_clk;
			nl += ls_clk;
			nd += hs_div[5];
		end
	endtask
	// completed reads against the oldest note
	always @(posedge pclk) begin
		if (psel === 1'b1 && penable === 1'b1 && pwrite === 1'b0 && pready === 1'b1) begin
			chk("prdata", exp_q.pop_front(), prdata);
		end
	end
	initial begin
		{presetn, psel, penable, pwrite, halt_req, wake_req, wdt_enable} = 7'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		seed = 68792;
		idle(4);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(scm_pkg::OFS_FAST_RC, scm_pkg::RST_FAST_RC);
		rd(scm_pkg::OFS_CLK_MODE, scm_pkg::RST_CLK_MODE);
		rd(scm_pkg::OFS_SLOW_XTAL, 8'h00);
		rd(8'h20, 8'h00);
		rd(scm_pkg::OFS_FAST_RC, 8'h03);
		for (int i = 0; i < 4; i++) begin
			rnd = 8'($random(seed));
			wr(scm_pkg::OFS_CLK_MODE, rnd);
			rd(scm_pkg::OFS_CLK_MODE, rnd & scm_pkg::CMC_WMASK);
		end
		wr(scm_pkg::OFS_CLK_MODE, 8'h00);
		wr(scm_pkg::OFS_FAST_XTAL, 8'h04);
		wr(scm_pkg::OFS_FAST_XTAL, 8'h05);
		rd(scm_pkg::OFS_FAST_XTAL, 8'h05);
		idle(30);
		wr(scm_pkg::OFS_FAST_XTAL, 8'h01);
		rd(scm_pkg::OFS_FAST_XTAL, 8'h07);
		chk("xt_rng", 32'h1, xt_rng);
		wr(scm_pkg::OFS_SLOW_XTAL, 8'h01);
		rd(scm_pkg::OFS_SLOW_XTAL, 8'h01);
		chk("sxt_en", 32'h1, osc_en[3]);
		idle(30);
		rd(scm_pkg::OFS_SLOW_XTAL, 8'h03);
		wr(scm_pkg::OFS_IRQ_MASK, 8'h00);
		idle(2);
		chk("irq", 32'h0, irq);
		wr(scm_pkg::OFS_IRQ_MASK, 8'h02);
		idle(2);
		chk("irq", 32'h1, irq);
		wr(scm_pkg::OFS_IRQ_STAT, 8'h02);
		idle(2);
		chk("irq", 32'h0, irq);
		nd = 8;
		for (int i = 1; i < 5; i++) begin
			md = {4'h0, 2'(i), 2'h1};
			wr(scm_pkg::OFS_FAST_RC, md);
			rd(scm_pkg::OFS_FAST_RC, md);
			chk("rc_mhz", nd, rc_mhz);
			idle(30);
			nd = (i == 1) ? 12 : (i == 2) ? 16 : 8;
			chk("rc_mhz", nd, rc_mhz);
			rd(scm_pkg::OFS_FAST_RC, md | 8'h02);
		end
		for (int k = 0; k < 8; k++) begin
			wr(scm_pkg::OFS_CLK_MODE, {3'(k), 5'h00});
			idle(8);
			cnt(512);
			near("sys_cnt", (k == 7) ? 32 : 256 >> k, ns);
			near("hs_cnt", 256, nh);
		end
		near("div64_cnt", 4, nd);
		wr(scm_pkg::OFS_CLK_MODE, 8'h0C);
		idle(8);
		cnt(512);
		near("hs_cnt", 170, nh);
		near("ls_cnt", 25, nl);
		for (int j = 0; j < 8; j++) begin
			md = {{3{j[2]}}, 3'h0, 2'(j)};
			wdt_enable <= j[2];
			wr(scm_pkg::OFS_CLK_MODE, md);
			hw(1'b1);
			chk("cpu_run", 32'h0, cpu_run);
			idle(4);
			cnt(256);
			chk("sys_run", (j[1] & j[0]) | (j[0] & ~j[1] & j[2]) | (j[1] & ~j[0] & ~j[2]),
				ns != 0);
			chk("hs_run", j[1], nh != 0);
			chk("ls_run", j[0], nl != 0);
			if (j[1:0] == 2'h0) chk("slow_rc_en", j[2], osc_en[2]);
			rd(scm_pkg::OFS_STATUS, MODE_V[j[1:0]]);
			hw(1'b0);
			chk("cpu_run", 32'h1, cpu_run);
		end
		idle(12);
		rd(scm_pkg::OFS_IRQ_STAT, 8'h0F);
		wr(scm_pkg::OFS_IRQ_STAT, 8'h08);
		rd(scm_pkg::OFS_IRQ_STAT, 8'h07);
		results();
	end
endmodule
